// file: logic/bts_addr_gen.sv
`timescale 1ns/100ps
module bts_addr_gen
  import bts_pkg::*;
(
  input  wire logic [15:0] base_i,
  input  wire logic [7:0]  disp_i,
  input  wire logic        add_disp_i,
  output logic      [15:0] addr_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // sign-extended displacement, wraps modulo 64k
  logic [15:0] disp_sx;

  assign disp_sx = {{8{disp_i[7]}}, disp_i};
  assign addr_o  = base_i + (add_disp_i ? disp_sx : RST_WORD);

endmodule // bts_addr_gen

// file: logic/bts_bit_ops.sv
`timescale 1ns/100ps
module bts_bit_ops
(
  input  wire logic [2:0] bit_sel_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] mask_o,
  output logic      [7:0] set_data_o,
  output logic            bit_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // index 0 is lsb
  function automatic logic [7:0] sel_mask(input logic [2:0] sel);
    sel_mask = 8'h01 << sel;
  endfunction

  // selected bit forced high, others pass untouched
  assign mask_o     = sel_mask(bit_sel_i);
  assign set_data_o = data_i | mask_o;
  assign bit_o      = |(data_i & mask_o);

endmodule // bts_bit_ops

// file: logic/bts_bit_unit.sv
// Operation
// - a bit test sets the zero flag when the chosen bit is 0 and clears it when it is 1.
// - a bit test forces the half carry flag to 1; sign and parity/overflow may hold any value.
// - a bit test clears the subtract flag and keeps the carry flag as it was.
// - the indexed test reads the byte at index_reg_y plus the sign-extended displacement.
// - the 3-bit bit-select field is a binary index, 000 is bit 0 and 111 is bit 7.
// - a bit test only reads memory and never writes the tested byte.
// - set-bit on a register decodes 000 B to 101 L and 111 A and forces the chosen bit to 1.
// - set-bit on memory reads the byte at pointer_pair, sets the bit, writes it back there.
// - set-bit in either form leaves every flag unchanged.
// - bit index 0 is the least significant bit and index 7 the most significant.
`timescale 1ns/100ps
module bts_bit_unit
  import bts_pkg::*;
(
  input  wire logic                          clk_sys_i,
  input  wire logic                          reset_n_i,
  input  wire logic [bts_pkg::AVS_ADDR_W-1:0] avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [31:0]                   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [31:0]                   avs_readdata_o,
  output logic                               avs_waitrequest_o,
  output logic      [15:0]                   mem_addr_o,
  output logic                               mem_rd_o,
  output logic                               mem_wr_o,
  output logic      [7:0]                    mem_wdata_o,
  input  wire logic [7:0]                    mem_rdata_i,
  input  wire logic                          mem_ack_i
);

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [7:0]  flags_r;
  logic [15:0] index_y_r, pointer_r;
  logic [7:0]  gpr_r [0:7];
  bts_op_e     op_r;
  logic [2:0]  bitsel_r, regsel_r;
  logic [7:0]  disp_r;
  logic        err_r;
  bts_state_e  state_r, state_nxt;
  logic [15:0] mem_addr_r, mem_addr_nxt;
  logic        mem_rd_r, mem_rd_nxt;
  logic        mem_wr_r, mem_wr_nxt;
  logic [7:0]  mem_wdata_r, mem_wdata_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle per access
  logic        bus_req, bus_take, wr_fire;
  logic [7:0]  word_addr;
  assign bus_req   = avs_read_i | avs_write_i;
  assign bus_take  = bus_req & wait_r;
  assign wr_fire   = avs_write_i & ~wait_r;
  assign word_addr = {avs_address_i[7:2], 2'b00};

  // address decode
  logic       hit_ctrl, hit_status, hit_flags, hit_index, hit_pointer, hit_gpr;
  logic [2:0] gpr_idx;
  logic       busy;
  assign hit_ctrl    = (word_addr == OFS_CTRL);
  assign hit_status  = (word_addr == OFS_STATUS);
  assign hit_flags   = (word_addr == OFS_FLAGS);
  assign hit_index   = (word_addr == OFS_INDEX_Y);
  assign hit_pointer = (word_addr == OFS_POINTER);
  assign gpr_idx     = word_addr[4:2];
  assign hit_gpr     = (word_addr >= OFS_GPR_BASE) && (word_addr <= OFS_GPR_LAST)
                       && (gpr_idx != REG_CODE_NONE);
  assign busy        = (state_r != ST_IDLE);
  // read value of the addressed word, unmapped reads as zero
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (hit_ctrl)
      rd_val = {16'h0000, disp_r, regsel_r, bitsel_r, op_r};
    else if (hit_status)
      rd_val = {30'h0000_0000, err_r, busy};
    else if (hit_flags)
      rd_val = {24'h00_0000, flags_r};
    else if (hit_index)
      rd_val = {16'h0000, index_y_r};
    else if (hit_pointer)
      rd_val = {16'h0000, pointer_r};
    else if (hit_gpr)
      rd_val = {24'h00_0000, gpr_r[gpr_idx]};
  end
  // byte lanes merge into the current value
  logic [31:0] be_mask;
  logic [31:0] wr_val;
  assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wr_val  = (rd_val & ~be_mask) | (avs_writedata_i & be_mask);
  // bus handshake registers
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wait_r <= ~bus_take;
      if (bus_take)
        rdata_r <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command decode
  bts_op_e    new_op;
  logic [2:0] new_bit, new_reg;
  logic [7:0] new_disp;
  logic       start_w, cmd_bad, go_w, reg_wr_ok;
  assign new_op    = bts_op_e'(wr_val[CTRL_OP_LSB +: 2]);
  assign new_bit   = wr_val[CTRL_BIT_LSB +: 3];
  assign new_reg   = wr_val[CTRL_REG_LSB +: 3];
  assign new_disp  = wr_val[CTRL_DISP_LSB +: 8];
  assign start_w   = wr_fire && hit_ctrl && !busy;
  assign cmd_bad   = (new_op == OP_BAD) || ((new_op == OP_SET_REG) && (new_reg == REG_CODE_NONE));
  assign go_w      = start_w && !cmd_bad;
  assign reg_wr_ok = wr_fire && !busy;
  // command fields and error flag, a new error beats a clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      op_r     <= OP_TEST_IDX;
      bitsel_r <= 3'h0;
      regsel_r <= 3'h0;
      disp_r   <= RST_BYTE;
      err_r    <= 1'b0;
    end
    else
    begin
      if (start_w)
      begin
        op_r     <= new_op;
        bitsel_r <= new_bit;
        regsel_r <= new_reg;
        disp_r   <= new_disp;
      end
      if (start_w && cmd_bad)
        err_r <= 1'b1;
      else if (wr_fire && hit_status && avs_byteenable_i[0] && avs_writedata_i[STAT_ERR])
        err_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bit datapaths and address generation
  logic [7:0]  mask_m, set_m, set_g;
  logic        bit_m, use_index;
  logic [15:0] start_addr;
  bts_bit_ops u_mem_bits
  (
    .bit_sel_i  (bitsel_r),
    .data_i     (mem_rdata_i),
    .mask_o     (mask_m),
    .set_data_o (set_m),
    .bit_o      (bit_m)
  );
  bts_bit_ops u_reg_bits
  (
    .bit_sel_i  (new_bit),
    .data_i     (gpr_r[new_reg]),
    .mask_o     (),
    .set_data_o (set_g),
    .bit_o      ()
  );
  assign use_index = (new_op == OP_TEST_IDX);
  // index plus displacement, or the pointer pair
  bts_addr_gen u_addr
  (
    .base_i     (use_index ? index_y_r : pointer_r),
    .disp_i     (new_disp),
    .add_disp_i (use_index),
    .addr_o     (start_addr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // memory sequencer
  logic rd_done, wr_done;
  assign rd_done = (state_r == ST_RD) && mem_ack_i;
  assign wr_done = (state_r == ST_WR) && mem_ack_i;

  always_comb
  begin
    state_nxt     = state_r;
    mem_addr_nxt  = mem_addr_r;
    mem_rd_nxt    = mem_rd_r;
    mem_wr_nxt    = mem_wr_r;
    mem_wdata_nxt = mem_wdata_r;
    case (state_r)
      ST_IDLE:
      begin
        if (go_w && (new_op != OP_SET_REG))
        begin
          state_nxt    = ST_RD;
          mem_addr_nxt = start_addr;
          mem_rd_nxt   = 1'b1;
        end
      end
      ST_RD:
      begin
        if (mem_ack_i)
        begin
          mem_rd_nxt = 1'b0;
          if (op_r == OP_TEST_IDX)
            state_nxt = ST_IDLE;
          else
          begin
            state_nxt     = ST_WR;
            mem_wdata_nxt = set_m;
            mem_wr_nxt    = 1'b1;
          end
        end
      end
      ST_WR:
      begin
        if (mem_ack_i)
        begin
          state_nxt  = ST_IDLE;
          mem_wr_nxt = 1'b0;
        end
      end
      default:
      begin
        state_nxt  = ST_IDLE;
        mem_rd_nxt = 1'b0;
        mem_wr_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r     <= ST_IDLE;
      mem_addr_r  <= RST_WORD;
      mem_rd_r    <= 1'b0;
      mem_wr_r    <= 1'b0;
      mem_wdata_r <= RST_BYTE;
    end
    else
    begin
      state_r     <= state_nxt;
      mem_addr_r  <= mem_addr_nxt;
      mem_rd_r    <= mem_rd_nxt;
      mem_wr_r    <= mem_wr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // set-bit never writes flags
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      flags_r <= RST_FLAGS;
    else if (rd_done && (op_r == OP_TEST_IDX))
    begin
      // zero flag is the inverted bit
      flags_r[FLG_Z] <= ~bit_m;
      flags_r[FLG_H] <= 1'b1;
      flags_r[FLG_N] <= 1'b0;
    end
    else if (reg_wr_ok && hit_flags)
      flags_r <= wr_val[7:0];
  end
  // pointer registers, writable only while idle
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      index_y_r <= RST_WORD;
      pointer_r <= RST_WORD;
    end
    else
    begin
      if (reg_wr_ok && hit_index)
        index_y_r <= wr_val[15:0];
      if (reg_wr_ok && hit_pointer)
        pointer_r <= wr_val[15:0];
    end
  end
  // general registers, set-bit acts in the start cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < 8; i++)
        gpr_r[i] <= RST_BYTE;
    end
    else if (go_w && (new_op == OP_SET_REG))
      gpr_r[new_reg] <= set_g;
    else if (reg_wr_ok && hit_gpr)
      gpr_r[gpr_idx] <= wr_val[7:0];
  end
  // outputs straight from flip-flops
  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign mem_addr_o        = mem_addr_r;
  assign mem_rd_o          = mem_rd_r;
  assign mem_wr_o          = mem_wr_r;
  assign mem_wdata_o       = mem_wdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  a_test_zero_flag: assert property ((rd_done && op_r == OP_TEST_IDX) |=>
    flags_r[FLG_Z] == ~|($past(mem_rdata_i) & $past(mask_m)))
    else $error("zero flag does not match tested bit");
  a_test_half_carry: assert property ((rd_done && op_r == OP_TEST_IDX) |=>
    flags_r[FLG_H])
    else $error("half carry not set by bit test");
  a_test_carry_kept: assert property ((rd_done && op_r == OP_TEST_IDX) |=>
    !flags_r[FLG_N] && flags_r[FLG_C] == $past(flags_r[FLG_C]))
    else $error("bit test changed carry or left subtract set");
  a_index_addr: assert property ((go_w && new_op == OP_TEST_IDX) |=>
    mem_rd_o && mem_addr_o == 16'($past(index_y_r) + {{8{$past(new_disp[7])}}, $past(new_disp)}))
    else $error("indexed address wrong");
  a_test_no_write: assert property ((busy && op_r == OP_TEST_IDX) |-> !mem_wr_o)
    else $error("bit test wrote memory");
  // register set check, index 0 is lsb
  a_setreg_bit: assert property ((go_w && new_op == OP_SET_REG) |=>
    gpr_r[$past(new_reg)] == ($past(gpr_r[new_reg]) | (8'h01 << $past(new_bit))))
    else $error("register set-bit result wrong");
  a_setmem_addr: assert property ((go_w && new_op == OP_SET_MEM) |=>
    mem_addr_o == $past(pointer_r) && mem_rd_o)
    else $error("set-bit memory address wrong");
  a_setmem_merge: assert property ((rd_done && op_r == OP_SET_MEM) |=>
    mem_wr_o && mem_wdata_o == ($past(mem_rdata_i) | (8'h01 << bitsel_r)))
    else $error("set-bit write-back data wrong");
  a_set_flags_kept: assert property (((go_w && new_op != OP_TEST_IDX) ||
    (busy && op_r == OP_SET_MEM)) |=> $stable(flags_r))
    else $error("set-bit changed a flag");
  a_bus_one_wait: assert property (bus_take |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");

  c_test_done: cover property (rd_done && op_r == OP_TEST_IDX);
  c_setreg: cover property (go_w && new_op == OP_SET_REG);
  c_setmem_done: cover property (wr_done);
  c_bad_cmd: cover property (start_w && cmd_bad);
endmodule // bts_bit_unit

// file: pkg/bts_pkg.sv
package bts_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register bus geometry and offsets (byte addresses, one 32-bit word each)
  localparam int         AVS_ADDR_W   = 8;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_FLAGS    = 8'h08;
  localparam logic [7:0] OFS_INDEX_Y  = 8'h0c;
  localparam logic [7:0] OFS_POINTER  = 8'h10;
  localparam logic [7:0] OFS_GPR_BASE = 8'h20;
  localparam logic [7:0] OFS_GPR_LAST = 8'h3c;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_BIT_LSB  = 2;
  localparam int CTRL_REG_LSB  = 5;
  localparam int CTRL_DISP_LSB = 8;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_ERR      = 1;
  localparam int FLG_C         = 0;
  localparam int FLG_N         = 1;
  localparam int FLG_PV        = 2;
  localparam int FLG_H         = 4;
  localparam int FLG_Z         = 6;
  localparam int FLG_S         = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and codes
  localparam logic [7:0]  RST_FLAGS     = 8'h00;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [2:0]  REG_CODE_NONE = 3'h6; // no general register at this code

  typedef enum logic [1:0] {
    OP_TEST_IDX = 2'h0,
    OP_SET_REG  = 2'h1,
    OP_SET_MEM  = 2'h2,
    OP_BAD      = 2'h3
  } bts_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RD   = 3'h2,
    ST_WR   = 3'h4
  } bts_state_e;

endpackage

// file: verification/bts_bit_unit_tb.sv
`timescale 1ns/100ps
module bts_bit_unit_tb;
  import bts_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [15:0] mem_addr_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic [7:0]  mem_rdata_i;
  logic        mem_ack_i;
  logic        slow;
  logic [31:0] rd;
  logic [7:0]  byte_v;
  logic [7:0]  flg_v;
  int          error_cnt = 0;
  int          check_count = 0;
  int          wr_base;
  logic [15:0] base_t [3] = '{16'h2000, 16'h0002, 16'h1080};
  logic [7:0]  disp_t [3] = '{8'h04, 8'hfc, 8'h80};
  logic [15:0] addr_t [3] = '{16'h2004, 16'hfffe, 16'h1000};
  logic [7:0]  data_t [3] = '{8'h5a, 8'ha5, 8'h3c};

  // 250 MHz system clock
  always #2 clk_sys_i = ~clk_sys_i;

  bts_bit_unit i_bts_bit_unit (.clk_sys_i, .reset_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i,
    .mem_ack_i);

  bts_mem_model i_mem (.clk_sys_i, .reset_n_i, .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
    .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o), .slow_i(slow),
    .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i), .wr_cnt_o());

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and compare
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // avalon access: hold until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    // waitrequest and read data are both taken at the rising edge
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    if (n >= 50)
      check("waitrequest", 1'b1, 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  // poll status until the command has finished
  task automatic idle;
    logic [31:0] q;
    int          n;
    n = 0;
    do
    begin
      rdr(OFS_STATUS, q);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 40);
    check("busy", 32'(q[STAT_BUSY]), 32'h0);
  endtask

  function automatic logic [31:0] cmd(logic [1:0] op, logic [2:0] b, logic [2:0] r,
                                      logic [7:0] d);
    return {16'h0000, d, r, b, op};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset_n_i        = 1'b0;
    avs_address_i    = 8'h00;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h0;
    avs_byteenable_i = 4'hf;
    slow             = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rdr(OFS_FLAGS, rd);
    check("flags_rst", rd, 32'h0);
    rdr(OFS_STATUS, rd);
    check("status_rst", rd, 32'h0);
    // indexed test over all bits, three displacements and both carry values
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 3; k++)
        for (int b = 0; b < 8; b++)
        begin
          slow <= b[0];
          flg_v = 8'h82 | 8'(c);
          i_mem.mem[addr_t[k]] = data_t[k];
          wr(OFS_INDEX_Y, 32'(base_t[k]));
          wr(OFS_FLAGS, 32'(flg_v));
          wr(OFS_CTRL, cmd(OP_TEST_IDX, 3'(b), 3'h0, disp_t[k]));
          idle();
          rdr(OFS_FLAGS, rd);
          check("test_flags", rd & 32'h53,
                32'(c) | 32'h10 | (32'(!data_t[k][b]) << FLG_Z));
        end
    check("test_writes", i_mem.wr_cnt_o, 0);
    check("test_byte", 32'(i_mem.mem[16'h2004]), 32'h5a);
    // set-bit on every register code but 110 and on every bit, flags left alone
    wr(OFS_FLAGS, 32'hd7);
    for (int r = 0; r < 8; r++)
      for (int b = 0; b < 8; b++)
        if (r != 6)
        begin
          wr(OFS_GPR_BASE + 8'(r * 4), 32'h24);
          wr(OFS_CTRL, cmd(OP_SET_REG, 3'(b), 3'(r), 8'h00));
          rdr(OFS_GPR_BASE + 8'(r * 4), rd);
          check("set_reg", rd, 32'h24 | (32'h1 << b));
        end
    rdr(OFS_FLAGS, rd);
    check("flags_set_reg", rd, 32'hd7);
    // refused commands and unmapped places
    for (int e = 0; e < 2; e++)
    begin
      wr(OFS_CTRL, e ? cmd(OP_BAD, 3'h0, 3'h0, 8'h0) : cmd(OP_SET_REG, 3'h1, 3'h6, 8'h0));
      rdr(OFS_STATUS, rd);
      check("err_set", rd, 32'h2);
      wr(OFS_STATUS, 32'h2);
      rdr(OFS_STATUS, rd);
      check("err_clr", rd, 32'h0);
    end
    rdr(8'h38, rd);
    check("gpr6_unmapped", rd, 32'h0);
    rdr(8'hfc, rd);
    check("unmapped", rd, 32'h0);
    // a disabled byte lane keeps its old value
    wr(OFS_INDEX_Y, 32'h1234);
    avs_byteenable_i <= 4'h1;
    wr(OFS_INDEX_Y, 32'habcd);
    avs_byteenable_i <= 4'hf;
    rdr(OFS_INDEX_Y, rd);
    check("index_lanes", rd, 32'h12cd);
    // set-bit in memory through the pointer pair, prompt and slow memory
    wr(OFS_POINTER, 32'h3000);
    i_mem.mem[16'h3000] = 8'h21;
    wr_base = i_mem.wr_cnt_o;
    for (int b = 0; b < 8; b++)
    begin
      slow <= b[1];
      byte_v = i_mem.mem[16'h3000];
      wr(OFS_CTRL, cmd(OP_SET_MEM, 3'(b), 3'h0, 8'h7f));
      idle();
      check("set_mem", 32'(i_mem.mem[16'h3000]), 32'(byte_v | (8'h01 << b)));
      check("set_mem_wr", i_mem.wr_cnt_o, wr_base + b + 1);
    end
    rdr(OFS_FLAGS, rd);
    check("flags_set_mem", rd, 32'hd7);
    rdr(OFS_CTRL, rd);
    check("ctrl_last", rd, cmd(OP_SET_MEM, 3'h7, 3'h0, 8'h7f));
    stop_test();
  end

  // watchdog against a hung handshake
  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule // bts_bit_unit_tb

// file: verification/bts_mem_model.sv
`timescale 1ns/100ps
module bts_mem_model
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [7:0]  mem_wdata_i,
  input  wire logic        slow_i,
  output logic      [7:0]  mem_rdata_o,
  output logic             mem_ack_o,
  output int               wr_cnt_o
);
  logic [7:0] mem [0:65535];
  int         wait_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // byte memory: acks after 0 or 3 wait cycles, read data only valid in the ack cycle
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= 8'h00;
      wait_cnt    <= 0;
      wr_cnt_o    <= 0;
    end
    else
    begin
      mem_ack_o <= 1'b0;
      if ((mem_rd_i || mem_wr_i) && !mem_ack_o && wait_cnt >= (slow_i ? 3 : 0))
      begin
        mem_ack_o <= 1'b1;
        wait_cnt  <= 0;
        if (mem_rd_i)
          mem_rdata_o <= mem[mem_addr_i];
        else
        begin
          mem[mem_addr_i] <= mem_wdata_i;
          wr_cnt_o        <= wr_cnt_o + 1;
        end
      end
      else
      begin
        // stale data does not stay on the bus, it is inverted in every cycle without an ack
        mem_rdata_o <= ~mem_rdata_o;
        if ((mem_rd_i || mem_wr_i) && !mem_ack_o)
          wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule // bts_mem_model
